// File: rhsc_ctrl.sv
// run/halt state control: run/halt flip-flop, halt sub-states and halt causes
// assumes console presses are one-cycle pulses synchronous to mclk
// How it works
// - machine is always either halted or running, never both.
// - halt offers display, load and a shared memory read/write sub-state.
// - idle halt loops a two-clock move of selected register to null.
// - load lasts two clocks, finish in the second.
// - load drives switch value on exchange, moves null into selected register.
// - read/write starts memory cycle at held address; read shows data.
// - read/write lasts five clocks, finish in the fifth.
// - start picks step, tape or run from the mode selector.
// - step executes the held micro then halts at its finish.
// - step branch or skip adds a two-clock no-op before halting.
// - tape start drives cassette forward when ready.
// - tape halts on parity, stop request, general clear or halt button.
// - halt from tape waits for micro finished; general clear halts at once.
// - run mode prefetches next micro while executing until a halt cause.
// - run halts on button, clear, halt micro, cassette start, parity errors.
// - one flip-flop gives complementary run and halt outputs.
// - after general clear the machine is halted.
// - start pulse lasts two clocks.
// - run sets on next finish during start if no refresh pending.
// - halt pulse lasts two clocks, latched until halted.
// - step mode decoded from neither run nor tape, both step flags true.
// - parity halt cause holds until general clear or cassette start.
`default_nettype none
module rhsc_ctrl
   import rhsc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // console
   input wire logic start_press,
   input wire logic halt_press,
   input wire logic load_press,
   input wire logic rw_press,
   input wire logic rw_is_write,
   input wire logic [WORD_W-1:0] switch_value,
   input wire rhsc_mode_t mode,
   input wire logic general_clear,
   // cassette
   input wire logic cassette_ready,
   output logic forward_drive,
   // sequencer and memory
   input wire logic seq_finished,
   input wire logic branch_skip,
   input wire logic demand_refresh_pending,
   input wire rhsc_cause_t cause,
   input wire logic [WORD_W-1:0] selected_reg_data,
   input wire logic [WORD_W-1:0] mem_read_data,
   output logic [WORD_W-1:0] mex_data,
   output rhsc_op_t micro_op,
   output logic mem_cycle_start,
   output logic mem_write,
   // state
   output logic micro_finished,
   output logic start_pulse,
   output logic halt_request_pulse,
   output logic run_state_out,
   output logic halt_state_out,
   output logic parity_halt_cause,
   output rhsc_state_t sub_state
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   rhsc_state_t state, next_state;
   logic [2:0] cnt, next_cnt;
   logic [1:0] start_cnt, next_start_cnt;
   logic [1:0] halt_cnt, next_halt_cnt;
   logic run, next_run;
   logic noop, next_noop;
   logic halt_latched, next_halt_latched;
   logic parity_hold, next_parity_hold;
   logic step_sel, next_step_sel;
   logic tape_sel, next_tape_sel;
   logic write_sel, next_write_sel;
   logic fwd, next_fwd;
   logic mstart, next_mstart;
   logic [WORD_W-1:0] mex, next_mex;
   rhsc_op_t op, next_op;
   logic fin, step_dec, halt_cause, halted;

   // complementary outputs of the single run flip-flop
   assign run_state_out = run;
   assign halt_state_out = ~run;
   assign halted = ~run;
   assign start_pulse = (start_cnt != 2'h0);
   assign halt_request_pulse = (halt_cnt != 2'h0);
   assign parity_halt_cause = parity_hold;
   assign sub_state = state;
   assign forward_drive = fwd;
   assign mex_data = mex;
   assign micro_op = op;
   assign mem_cycle_start = mstart;
   assign mem_write = write_sel;
   assign micro_finished = fin;

   // step decode from the mode selector
   assign step_dec = !mode.run_sel && !mode.tape_mode_flag
                     && mode.single_step_flag && mode.step_run_flag;
   // ----------------------------------------
   // finish timing and halt causes
   // ----------------------------------------
   always_comb begin
      case (state)
         ST_DISPLAY: fin = (cnt == DISPLAY_CYCLES - 3'h1);
         ST_LOAD: fin = (cnt == LOAD_CYCLES - 3'h1);
         ST_RW: fin = (cnt == RW_CYCLES - 3'h1);
         ST_RUN: fin = noop ? (cnt == NOOP_CYCLES - 3'h1) : seq_finished;
         default: fin = 1'b0;
      endcase
      // tape and run causes; step halts on its own finish
      halt_cause = halt_latched || parity_hold;
      if (tape_sel) begin
         halt_cause = halt_cause || cause.tape_stop;
      end else if (!step_sel) begin
         halt_cause = halt_cause || cause.halt_micro || cause.cassette_start;
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_cnt = cnt + 3'h1;
      next_run = run;
      next_noop = noop;
      next_step_sel = step_sel;
      next_tape_sel = tape_sel;
      next_write_sel = write_sel;
      next_mstart = 1'b0;
      next_mex = mex;
      next_op = op;
      // two-clock start and halt pulses
      next_start_cnt = (start_cnt != 2'h0) ? start_cnt - 2'h1 : 2'h0;
      if (start_press && halted && start_cnt == 2'h0) begin
         next_start_cnt = PULSE_CYCLES;
      end
      next_halt_cnt = (halt_cnt != 2'h0) ? halt_cnt - 2'h1 : 2'h0;
      if (halt_press && halt_cnt == 2'h0) begin
         next_halt_cnt = PULSE_CYCLES;
      end
      // halt request held until halted
      next_halt_latched = (halt_request_pulse && run) || (halt_latched && run);
      // parity cause holds; a new error wins over a clear
      next_parity_hold = parity_hold && !general_clear && !cause.cassette_start;
      if (run && (cause.tape_parity_error
                  || (!tape_sel && !step_sel && cause.mem_parity_error && cause.next_micro_prefetch))) begin
         next_parity_hold = 1'b1;
      end
      case (state)
         ST_DISPLAY: begin
            // idle loop: selected register onto the exchange
            next_op = OP_MOVE_TO_NULL;
            next_mex = selected_reg_data;
            if (fin) begin
               next_cnt = CNT_RESET;
            end
            if (start_pulse && fin && !demand_refresh_pending) begin
               next_run = 1'b1;
               next_state = ST_RUN;
               next_cnt = CNT_RESET;
               next_step_sel = step_dec;
               next_tape_sel = mode.tape_mode_flag;
               next_op = OP_SEQUENCER;
            end else if (load_press) begin
               next_state = ST_LOAD;
               next_cnt = CNT_RESET;
               next_op = OP_MOVE_FROM_NULL;
               next_mex = switch_value;
            end else if (rw_press) begin
               next_state = ST_RW;
               next_cnt = CNT_RESET;
               next_mstart = 1'b1;
               next_write_sel = rw_is_write;
               next_op = rw_is_write ? OP_WRITE_FROM_NULL : OP_READ_TO_NULL;
               next_mex = rw_is_write ? switch_value : mex;
            end
         end
         ST_LOAD: begin
            next_mex = switch_value;
            if (fin) begin
               next_state = ST_DISPLAY;
               next_cnt = CNT_RESET;
            end
         end
         ST_RW: begin
            // read shows memory data, write keeps the switches
            next_mex = write_sel ? switch_value : mem_read_data;
            if (fin) begin
               next_state = ST_DISPLAY;
               next_cnt = CNT_RESET;
               next_write_sel = 1'b0;
            end
         end
         ST_RUN: begin
            if (!noop) begin
               next_cnt = CNT_RESET;
            end
            if (fin) begin
               if (noop) begin
                  next_run = 1'b0;
               end else if (step_sel && branch_skip) begin
                  next_noop = 1'b1;
                  next_op = OP_NOOP;
               end else if (step_sel || halt_cause) begin
                  next_run = 1'b0;
               end
            end
            if (!next_run) begin
               // halt only after the running micro finishes
               next_state = ST_DISPLAY;
               next_cnt = CNT_RESET;
               next_noop = 1'b0;
               next_op = OP_MOVE_TO_NULL;
            end
         end
         default: begin
            next_state = ST_DISPLAY;
            next_cnt = CNT_RESET;
         end
      endcase
      // cassette forward drive while running in tape mode
      next_fwd = next_run && next_tape_sel && cassette_ready;
      // general clear forces the halt sub-state at once
      if (general_clear) begin
         next_run = 1'b0;
         next_state = ST_DISPLAY;
         next_cnt = CNT_RESET;
         next_noop = 1'b0;
         next_fwd = 1'b0;
         next_start_cnt = 2'h0;
         next_halt_latched = 1'b0;
         next_op = OP_MOVE_TO_NULL;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_DISPLAY;
         cnt <= CNT_RESET;
         start_cnt <= 2'h0;
         halt_cnt <= 2'h0;
         run <= 1'b0;
         noop <= 1'b0;
         halt_latched <= 1'b0;
         parity_hold <= 1'b0;
         step_sel <= 1'b0;
         tape_sel <= 1'b0;
         write_sel <= 1'b0;
         fwd <= 1'b0;
         mstart <= 1'b0;
         mex <= 24'h000000;
         op <= OP_MOVE_TO_NULL;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         start_cnt <= next_start_cnt;
         halt_cnt <= next_halt_cnt;
         run <= next_run;
         noop <= next_noop;
         halt_latched <= next_halt_latched;
         parity_hold <= next_parity_hold;
         step_sel <= next_step_sel;
         tape_sel <= next_tape_sel;
         write_sel <= next_write_sel;
         fwd <= next_fwd;
         mstart <= next_mstart;
         mex <= next_mex;
         op <= next_op;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence s_load_entry;
      state == ST_LOAD && $past(state) != ST_LOAD;
   endsequence
   sequence s_rw_entry;
      state == ST_RW && $past(state) != ST_RW;
   endsequence
   property p_one_state;
      run_state_out == (state == ST_RUN);
   endproperty
   a_one_state: assert property (p_one_state) else $error("run flag and sub-state disagree");
   property p_load_len;
      s_load_entry ##0 !general_clear |-> !micro_finished ##1 micro_finished ##1 state == ST_DISPLAY;
   endproperty
   a_load_len: assert property (p_load_len) else $error("load sub-state not two clocks");
   property p_rw_len;
      s_rw_entry ##0 !general_clear |-> !micro_finished [*4] ##1 micro_finished ##1 state == ST_DISPLAY;
   endproperty
   a_rw_len: assert property (p_rw_len) else $error("read/write sub-state not five clocks");
   property p_start_len;
      $rose(start_pulse) && !general_clear |-> start_pulse [*2] ##1 !start_pulse;
   endproperty
   a_start_len: assert property (p_start_len) else $error("start pulse not two clocks");
   property p_halt_latch;
      halt_request_pulse && run_state_out && !general_clear |=> halt_latched || halt_state_out;
   endproperty
   a_halt_latch: assert property (p_halt_latch) else $error("halt request not held");
   property p_run_set;
      halt_state_out && state == ST_DISPLAY && start_pulse && micro_finished
         && !demand_refresh_pending && !general_clear |=> run_state_out;
   endproperty
   a_run_set: assert property (p_run_set) else $error("run did not set at finish");
   property p_refresh_blocks;
      halt_state_out && demand_refresh_pending |=> halt_state_out;
   endproperty
   a_refresh_blocks: assert property (p_refresh_blocks) else $error("run set during refresh");
   property p_gclr;
      general_clear |=> halt_state_out && state == ST_DISPLAY && !forward_drive;
   endproperty
   a_gclr: assert property (p_gclr) else $error("general clear did not halt");
   property p_parity_hold;
      parity_halt_cause && !general_clear && !cause.cassette_start |=> parity_halt_cause;
   endproperty
   a_parity_hold: assert property (p_parity_hold) else $error("parity cause dropped early");
   property p_step_noop;
      run_state_out && step_sel && !noop && seq_finished && branch_skip && !general_clear
         |=> run_state_out ##1 (run_state_out || general_clear) ##1 halt_state_out;
   endproperty
   a_step_noop: assert property (p_step_noop) else $error("step no-op timing wrong");
   property p_tape_wait;
      run_state_out && tape_sel && !micro_finished && !general_clear |=> run_state_out;
   endproperty
   a_tape_wait: assert property (p_tape_wait) else $error("tape halted before finish");
endmodule
`default_nettype wire

// File: rhsc_ctrl_tb.sv
// self-checking bench for the run/halt controller
// assumes the sequencer model in rhsc_seq_model.sv
`default_nettype none
module rhsc_ctrl_tb
   import rhsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic start_press = 1'b0, halt_press = 1'b0, load_press = 1'b0, rw_press = 1'b0, rw_is_write = 1'b0;
   logic general_clear = 1'b0, cassette_ready = 1'b0, branch_skip = 1'b0, demand_refresh_pending = 1'b0;
   logic [WORD_W-1:0] switch_value = 24'h0, selected_reg_data = 24'h0, mem_read_data = 24'h0;
   rhsc_mode_t mode = 4'h0;
   rhsc_cause_t cause = 6'h0;
   logic [3:0] latency = 4'h1;
   logic forward_drive, mem_cycle_start, mem_write, micro_finished, start_pulse, halt_request_pulse;
   logic run_state_out, halt_state_out, parity_halt_cause, seq_finished;
   logic [WORD_W-1:0] mex_data;
   rhsc_op_t micro_op;
   rhsc_state_t sub_state;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int run_cycles = 0;
   // clock
   always #5 mclk = ~mclk;
   rhsc_ctrl DUT (.mclk(mclk), .reset_n(reset_n), .start_press(start_press), .halt_press(halt_press),
      .load_press(load_press), .rw_press(rw_press), .rw_is_write(rw_is_write), .switch_value(switch_value),
      .mode(mode), .general_clear(general_clear), .cassette_ready(cassette_ready),
      .forward_drive(forward_drive), .seq_finished(seq_finished), .branch_skip(branch_skip),
      .demand_refresh_pending(demand_refresh_pending), .cause(cause), .selected_reg_data(selected_reg_data),
      .mem_read_data(mem_read_data), .mex_data(mex_data), .micro_op(micro_op),
      .mem_cycle_start(mem_cycle_start), .mem_write(mem_write), .micro_finished(micro_finished),
      .start_pulse(start_pulse), .halt_request_pulse(halt_request_pulse), .run_state_out(run_state_out),
      .halt_state_out(halt_state_out), .parity_halt_cause(parity_halt_cause), .sub_state(sub_state));
   rhsc_seq_model seq (.mclk(mclk), .reset_n(reset_n), .run_state_out(run_state_out), .micro_op(micro_op),
      .latency(latency), .seq_finished(seq_finished));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic summarize;
      if (n_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic tick;
      @(posedge mclk);
      #1;
   endtask
   // wait for a run/halt level, bounded
   task automatic wait_run(input logic v);
      for (int i = 0; i < 40 && run_state_out !== v; i++) begin
         tick();
      end
      chk(run_state_out === v, "run state not reached");
      chk((run_state_out ^ halt_state_out) === 1'b1, "outputs not complementary");
   endtask
   // one-cycle button press: 0 start, 1 load, 2 read/write, 3 halt
   task automatic press(input int b);
      @(posedge mclk);
      {halt_press, rw_press, load_press, start_press} <= 4'h1 << b;
      @(posedge mclk);
      {halt_press, rw_press, load_press, start_press} <= 4'h0;
      #1;
   endtask
   task automatic start_run(input logic [3:0] m, input logic [3:0] l);
      @(posedge mclk);
      mode <= m;
      latency <= l;
      press(0);
      chk(start_pulse === 1'b1, "start pulse c1");
      tick();
      chk(start_pulse === 1'b1, "start pulse c2");
      tick();
      chk(start_pulse === 1'b0, "start pulse c3");
   endtask
   task automatic clear;
      @(posedge mclk);
      general_clear <= 1'b1;
      @(posedge mclk);
      #1;
      chk(run_state_out === 1'b0 && halt_state_out === 1'b1, "clear did not halt");
      @(posedge mclk);
      general_clear <= 1'b0;
      #1;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_display;
      int n = 0;
      @(posedge mclk);
      selected_reg_data <= 24'ha5c3e1;
      repeat (3) tick();
      chk(sub_state === ST_DISPLAY && micro_op === OP_MOVE_TO_NULL, "display op");
      chk(mex_data === 24'ha5c3e1, "display exchange");
      repeat (4) begin
         tick();
         n += (micro_finished === 1'b1);
      end
      chk(n == 2, "display finish rate");
   endtask
   task automatic t_load;
      @(posedge mclk);
      switch_value <= 24'h3c5a96;
      press(1);
      chk(sub_state === ST_LOAD && micro_op === OP_MOVE_FROM_NULL, "load op");
      chk(mex_data === 24'h3c5a96 && micro_finished === 1'b0, "load c1");
      tick();
      chk(micro_finished === 1'b1, "load finish");
      tick();
      chk(sub_state === ST_DISPLAY, "load end");
   endtask
   task automatic t_rw(input logic w);
      @(posedge mclk);
      rw_is_write <= w;
      mem_read_data <= 24'h5e0f71;
      press(2);
      chk(sub_state === ST_RW && mem_cycle_start === 1'b1 && mem_write === w, "rw c1");
      repeat (3) begin
         tick();
         chk(micro_finished === 1'b0 && mem_cycle_start === 1'b0, "rw early");
      end
      tick();
      chk(micro_finished === 1'b1, "rw finish");
      chk(mex_data === (w ? 24'h3c5a96 : 24'h5e0f71), "rw data");
      chk(micro_op === (w ? OP_WRITE_FROM_NULL : OP_READ_TO_NULL), "rw op");
      tick();
      chk(sub_state === ST_DISPLAY, "rw end");
   endtask
   task automatic t_step;
      int n;
      n = run_cycles;
      start_run(4'h3, 4'h2);
      wait_run(1'b1);
      wait_run(1'b0);
      // one micro of latency+1 clocks, whatever the display phase at start
      chk(run_cycles - n == 3 && halt_state_out === 1'b1, "step length");
   endtask
   task automatic t_branch;
      @(posedge mclk);
      branch_skip <= 1'b1;
      start_run(4'h3, 4'h1);
      wait_run(1'b1);
      for (int i = 0; i < 10 && seq_finished !== 1'b1; i++) begin
         tick();
      end
      tick();
      chk(run_state_out === 1'b1 && micro_op === OP_NOOP, "no-op c1");
      tick();
      chk(run_state_out === 1'b1 && micro_finished === 1'b1, "no-op c2");
      tick();
      chk(run_state_out === 1'b0, "no-op halt");
      @(posedge mclk);
      branch_skip <= 1'b0;
   endtask
   task automatic t_refresh;
      @(posedge mclk);
      demand_refresh_pending <= 1'b1;
      start_run(4'h3, 4'h1);
      repeat (3) tick();
      chk(run_state_out === 1'b0, "run set under refresh");
      @(posedge mclk);
      demand_refresh_pending <= 1'b0;
      start_run(4'h3, 4'h1);
      wait_run(1'b1);
      wait_run(1'b0);
   endtask
   // halt micro, cassette start, tape parity, prefetch parity
   task automatic t_causes;
      logic [5:0] codes[4] = '{6'h20, 6'h01, 6'h08, 6'h06};
      foreach (codes[k]) begin
         start_run(4'h8, 4'h1);
         wait_run(1'b1);
         @(posedge mclk);
         cause <= codes[k];
         wait_run(1'b0);
         @(posedge mclk);
         cause <= 6'h0;
         repeat (3) tick();
         chk(parity_halt_cause === (k >= 2), "parity cause hold");
         clear();
         chk(parity_halt_cause === 1'b0, "parity cause clear");
      end
   endtask
   task automatic t_halt;
      start_run(4'h8, 4'h1);
      wait_run(1'b1);
      repeat (10) tick();
      chk(run_state_out === 1'b1, "run stopped early");
      press(3);
      chk(halt_request_pulse === 1'b1, "halt pulse c1");
      tick();
      chk(halt_request_pulse === 1'b1, "halt pulse c2");
      tick();
      chk(halt_request_pulse === 1'b0, "halt pulse c3");
      wait_run(1'b0);
      start_run(4'h8, 4'h1);
      wait_run(1'b1);
      clear();
   endtask
   task automatic t_tape;
      @(posedge mclk);
      cassette_ready <= 1'b1;
      start_run(4'h4, 4'h6);
      wait_run(1'b1);
      @(posedge mclk);
      cause <= 6'h10;
      tick();
      chk(forward_drive === 1'b1, "forward drive");
      tick();
      chk(run_state_out === 1'b1, "tape stop before finish");
      wait_run(1'b0);
      @(posedge mclk);
      cause <= 6'h0;
      cassette_ready <= 1'b0;
      start_run(4'h4, 4'h1);
      wait_run(1'b1);
      tick();
      chk(forward_drive === 1'b0, "drive without ready");
      press(3);
      wait_run(1'b0);
   endtask
   // ----------------------------------------
   // main sequence and timeout
   // ----------------------------------------
   // count cycles spent running, sampled mid-cycle where outputs are settled
   always @(negedge mclk) begin
      if (run_state_out === 1'b1) begin
         run_cycles++;
      end
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         $display("[FAIL] %0t timeout", $time);
         summarize();
      end
   end
   initial begin
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      chk(halt_state_out === 1'b1 && run_state_out === 1'b0, "reset state");
      chk(sub_state === ST_DISPLAY, "reset sub-state");
      t_display();
      t_load();
      t_rw(1'b0);
      t_rw(1'b1);
      t_step();
      t_branch();
      t_refresh();
      t_causes();
      t_halt();
      t_tape();
      summarize();
   end
endmodule
`default_nettype wire

// File: rhsc_pkg.sv
// run/halt state control: shared constants and types
// assumes one 100 MHz clock domain shared with the sequencer
`default_nettype none
package rhsc_pkg;
   // ----------------------------------------
   // widths and sub-state timing
   // ----------------------------------------
   localparam int WORD_W = 24;
   localparam logic [2:0] DISPLAY_CYCLES = 3'h2;
   localparam logic [2:0] LOAD_CYCLES = 3'h2;
   localparam logic [2:0] RW_CYCLES = 3'h5;
   localparam logic [2:0] NOOP_CYCLES = 3'h2;
   localparam logic [1:0] PULSE_CYCLES = 2'h2;
   localparam logic [2:0] CNT_RESET = 3'h0;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_DISPLAY = 2'h0,
      ST_LOAD = 2'h1,
      ST_RW = 2'h3,
      ST_RUN = 2'h2
   } rhsc_state_t;
   typedef enum logic [2:0] {
      OP_MOVE_TO_NULL = 3'h0,
      OP_MOVE_FROM_NULL = 3'h1,
      OP_READ_TO_NULL = 3'h2,
      OP_WRITE_FROM_NULL = 3'h3,
      OP_NOOP = 3'h4,
      OP_SEQUENCER = 3'h5
   } rhsc_op_t;
   // mode selector decode
   typedef struct packed {
      logic run_sel;
      logic tape_mode_flag;
      logic single_step_flag;
      logic step_run_flag;
   } rhsc_mode_t;
   // halt causes reported by the rest of the processor
   typedef struct packed {
      logic halt_micro;
      logic tape_stop;
      logic tape_parity_error;
      logic mem_parity_error;
      logic next_micro_prefetch;
      logic cassette_start;
   } rhsc_cause_t;
endpackage
`default_nettype wire

// File: rhsc_seq_model.sv
// sequencer stand-in: finishes each run-state micro after a set latency
// assumes the controller marks sequencer micros on micro_op
`default_nettype none
module rhsc_seq_model
   import rhsc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // controller side
   input wire logic run_state_out,
   input wire rhsc_op_t micro_op,
   input wire logic [3:0] latency,
   output logic seq_finished
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // micro length counter
   // ----------------------------------------
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic busy;
   // finish pulse after latency+1 clocks of one micro
   assign busy = run_state_out && (micro_op == OP_SEQUENCER);
   assign seq_finished = busy && (cnt == latency);
   always_comb begin
      next_cnt = (busy && !seq_finished) ? cnt + 4'h1 : 4'h0;
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 4'h0;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule
`default_nettype wire
